// *** tcs_pkg.sv ***
package tcs_pkg;
  // stream geometry
  localparam int STREAMS    = 8;
  localparam int CHANNELS   = 32;
  localparam int MEM_DEPTH  = 256;
  localparam int LINE_KBPS  = 2048;  // serial rate of every stream
  localparam int HALF_CELLS = 512;   // clock periods of the 4 MHz pin per frame
  // system clock and reset timing
  localparam int SYS_PERIOD_NS    = 20;
  localparam int RESET_MIN_NS     = 100;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // mode_and_page_select register
  localparam logic [5:0] CR_OFFSET    = 6'h00;
  localparam logic [7:0] CR_RESET     = 8'h00;
  localparam int         CR_SPLIT     = 7;
  localparam int         CR_BCAST     = 6;
  localparam int         CR_MSEL_LO   = 3;
  localparam int         CR_STREAM_LO = 0;
  localparam logic [1:0] MSEL_CML     = 2'h2;
  localparam logic [1:0] MSEL_CMH     = 2'h3;
  // high connection entry fields
  localparam int         CMH_OE   = 0;
  localparam int         CMH_CST  = 1;
  localparam int         CMH_MSG  = 2;
  localparam logic [7:0] CMH_MASK = 8'h07;
  // frame counter and stream step values
  localparam logic [8:0] CNT_RESET = 9'h000;
  localparam logic [3:0] CH_FIRST  = 4'h0;
  localparam logic [3:0] CH_LAST   = 4'hf;
  localparam logic [2:0] S_LAST    = 3'h7;
  // engine states
  typedef enum logic [6:0] {
    E_IDLE  = 7'h01,
    E_WRITE = 7'h02,
    E_FETCH = 7'h04,
    E_ROUTE = 7'h08,
    E_STORE = 7'h10,
    E_HOST  = 7'h20,
    E_HREAD = 7'h40
  } tcs_eng_t;
  // host port states
  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_WAIT = 3'h2,
    H_ACK  = 3'h4
  } tcs_host_t;
  // synchronised host pins
  typedef struct packed {
    logic       cs_n;
    logic       ds;
    logic       rw;
    logic       region;
    logic [4:0] idx;
    logic [7:0] data;
  } tcs_host_pins_t;
  // one received channel of all streams
  typedef struct packed {
    logic [4:0]      chan;
    logic [7:0][7:0] bytes;
  } tcs_in_word_t;
endpackage : tcs_pkg

// *** tcs_ram.sv ***
`timescale 1ns/1ps
module tcs_ram
  import tcs_pkg::*;
(
  // clock
  input  wire logic       clk_sys,
  // write port
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  // read port
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:MEM_DEPTH-1];  // contents survive reset on purpose

  // write side
  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // registered read, one cycle latency
  always_ff @(posedge clk_sys)
  begin
    rdata <= mem[raddr];
  end
endmodule : tcs_ram

// *** tcs_switch.sv ***
`timescale 1ns/1ps
module tcs_switch
  import tcs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // timing pins
  input  wire logic       bit_clock_4m_n,
  input  wire logic       frame_pulse_n,
  // serial streams
  input  wire logic [7:0] serial_in_stream,
  input  wire logic       output_driver_gate,
  output logic      [7:0] serial_out_stream,
  output logic      [7:0] serial_out_oe,
  output logic            control_bit_serial_out,
  // host port
  input  wire logic       chip_select_n,
  input  wire logic       data_strobe,
  input  wire logic       read_write,
  input  wire logic       region_select_line,
  input  wire logic [4:0] channel_index_lines,
  input  wire logic [7:0] host_data_bus_in,
  output logic      [7:0] host_data_bus_out,
  output logic            host_data_bus_oe,
  output logic            transfer_ack_n,
  output logic            transfer_ack_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // synchronisers, first stage read only by second
  logic [1:0]     c4_sync;
  logic [1:0]     fp_sync;
  logic [7:0]     in_sync1, in_s;
  logic           gate_sync1, gate_s;
  tcs_host_pins_t hp_sync1, hp;
  logic           c4_d;     // previous synced clock level
  // frame timing
  logic [8:0]     cnt;      // half-cell count within frame
  logic           fall, tick, mid, start, ch_start, last;
  // control register and host side
  logic [7:0]     cr;
  tcs_host_t      h_state;
  tcs_host_pins_t hq;       // access latched at strobe
  logic           sel;
  logic [7:0]     h_addr;
  logic [7:0]     h_rd;
  // engine
  tcs_eng_t       eng;
  logic [2:0]     eng_s;    // stream step
  logic [4:0]     eng_ch1, eng_ch2;
  logic           job;
  logic [7:0]     cml_q, cmh_q;
  logic [7:0][7:0] nxt_byte;
  logic [7:0]     nxt_oe, nxt_cst;
  // memories
  logic           dm_we, cml_we, cmh_we;
  logic [7:0]     dm_waddr, dm_wdata, dm_raddr, cm_raddr;
  logic [7:0]     dm_rdata, cml_rdata, cmh_rdata;
  // receive path and two-entry buffer
  logic [7:0][7:0] in_sh;
  logic           cap_go, cap_valid, in_ready, fifo_valid, push, pop;
  tcs_in_word_t   cap_word, head;
  tcs_in_word_t   fifo_mem [2];
  logic [1:0]     fifo_cnt;
  logic           wr_ptr, rd_ptr;
  // transmit path
  logic [7:0][7:0] out_sh;
  logic [7:0]     cur_oe, cst_sh;

  // pin synchronisers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      c4_sync    <= 2'h3;
      fp_sync    <= 2'h3;
      in_sync1   <= 8'hff;
      in_s       <= 8'hff;
      gate_sync1 <= 1'b0;
      gate_s     <= 1'b0;
      hp_sync1   <= '{cs_n: 1'b1, default: '0};
      hp         <= '{cs_n: 1'b1, default: '0};
      c4_d       <= 1'b1;
    end
    else
    begin
      c4_sync    <= {c4_sync[0], bit_clock_4m_n};
      fp_sync    <= {fp_sync[0], frame_pulse_n};
      in_sync1   <= serial_in_stream;
      in_s       <= in_sync1;
      gate_sync1 <= output_driver_gate;
      gate_s     <= gate_sync1;
      hp_sync1   <= '{chip_select_n, data_strobe, read_write,
                      region_select_line, channel_index_lines, host_data_bus_in};
      hp         <= hp_sync1;
      c4_d       <= c4_sync[1];
    end
  end

  assign fall = c4_d & ~c4_sync[1];  // falling edge of the 4 MHz pin

  // frame counter; no other time base is used
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt  <= CNT_RESET;
      tick <= 1'b0;
    end
    else
    begin
      tick <= fall;
      if (fall)
      begin
        cnt <= fp_sync[1] ? cnt + 9'h001 : CNT_RESET;
      end
    end
  end

  // events seen one cycle after the edge, with the new count
  assign mid      = tick & cnt[0];
  assign start    = tick & ~cnt[0];
  assign ch_start = tick & (cnt[3:0] == CH_FIRST);
  assign last     = tick & (cnt[3:0] == CH_LAST);

  a_frame_zero: assert property (fall && !fp_sync[1] |=> cnt == CNT_RESET);
  a_count_step: assert property (fall && fp_sync[1] |=> cnt == $past(cnt) + 9'h001);

  // per stream receive and transmit shifters
  for (genvar s = 0; s < STREAMS; s++)
  begin : g_stream
    // receive: sample in the middle of each cell, msb first
    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        in_sh[s] <= 8'h00;
      end
      else if (mid)
      begin
        in_sh[s] <= {in_sh[s][6:0], in_s[s]};
      end
    end
    // transmit: new byte at channel start, shift at cell start
    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        out_sh[s]            <= 8'h00;
        serial_out_stream[s] <= 1'b1;
        cur_oe[s]            <= 1'b0;
        serial_out_oe[s]     <= 1'b0;
      end
      else
      begin
        if (ch_start)
        begin
          serial_out_stream[s] <= nxt_byte[s][7];
          out_sh[s]            <= {nxt_byte[s][6:0], 1'b0};
          cur_oe[s]            <= nxt_oe[s];
        end
        else if (start)
        begin
          serial_out_stream[s] <= out_sh[s][7];
          out_sh[s]            <= {out_sh[s][6:0], 1'b0};
        end
        // gate acts at once, not only at channel edges
        serial_out_oe[s] <= gate_s & cur_oe[s];
      end
    end
  end

  a_gate_float: assert property (!gate_s |=> serial_out_oe == 8'h00);

  // control bit stream, one channel ahead, stream 0 first
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cst_sh                 <= 8'h00;
      control_bit_serial_out <= 1'b0;
    end
    else if (ch_start)
    begin
      control_bit_serial_out <= nxt_cst[0];
      cst_sh                 <= {1'b0, nxt_cst[7:1]};
    end
    else if (start)
    begin
      control_bit_serial_out <= cst_sh[0];
      cst_sh                 <= {1'b0, cst_sh[7:1]};
    end
  end

  // case equality: entries never written by the host read back unknown
  a_cst_first: assert property (ch_start |=> control_bit_serial_out === $past(nxt_cst[0]));

  // captured byte is held until the buffer takes it
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cap_go    <= 1'b0;
      cap_valid <= 1'b0;
      cap_word  <= '0;
    end
    else
    begin
      cap_go <= last;
      if (cap_go)
      begin
        cap_word  <= '{chan: cnt[8:4], bytes: in_sh};
        cap_valid <= 1'b1;
      end
      else if (in_ready)
      begin
        cap_valid <= 1'b0;
      end
    end
  end

  // two-entry buffer between receiver and data memory writer
  assign in_ready   = (fifo_cnt != 2'h2);
  assign fifo_valid = (fifo_cnt != 2'h0);
  assign push       = cap_valid & in_ready;
  assign pop        = (eng == E_WRITE) && (eng_s == S_LAST);
  assign head       = fifo_mem[rd_ptr];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fifo_cnt <= 2'h0;
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        fifo_mem[wr_ptr] <= cap_word;
        wr_ptr           <= ~wr_ptr;
      end
      if (pop)
      begin
        rd_ptr <= ~rd_ptr;
      end
      fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // memory engine; serial work has priority over the host
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      eng     <= E_IDLE;
      eng_s   <= 3'h0;
      eng_ch1 <= 5'h00;
      eng_ch2 <= 5'h00;
      job     <= 1'b0;
    end
    else
    begin
      if (ch_start)
      begin
        eng_ch1 <= cnt[8:4] + 5'h01;
        eng_ch2 <= cnt[8:4] + 5'h02;
      end
      unique case (eng)
        E_IDLE:
        begin
          eng_s <= 3'h0;
          if (fifo_valid)
          begin
            eng <= E_WRITE;
          end
          else if (job)
          begin
            eng <= E_FETCH;
          end
          else if (h_state == H_WAIT)
          begin
            eng <= E_HOST;
          end
        end
        E_WRITE:
        begin
          eng_s <= eng_s + 3'h1;
          if (eng_s == S_LAST)
          begin
            eng <= E_IDLE;
          end
        end
        E_FETCH: eng <= E_ROUTE;
        E_ROUTE: eng <= E_STORE;
        E_STORE:
        begin
          eng_s <= eng_s + 3'h1;
          eng   <= (eng_s == S_LAST) ? E_IDLE : E_FETCH;
        end
        E_HOST:  eng <= E_HREAD;
        E_HREAD: eng <= E_IDLE;
        default: eng <= E_IDLE;
      endcase
      // a new channel start wins over the clear
      if (ch_start)
      begin
        job <= 1'b1;
      end
      else if (eng == E_IDLE && !fifo_valid && job)
      begin
        job <= 1'b0;
      end
    end
  end

  // route step results for the next channel
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cml_q    <= 8'h00;
      cmh_q    <= 8'h00;
      nxt_byte <= '0;
      nxt_oe   <= 8'h00;
      nxt_cst  <= 8'h00;
    end
    else if (eng == E_ROUTE)
    begin
      cml_q <= cml_rdata;
      cmh_q <= cmh_rdata;
    end
    else if (eng == E_STORE)
    begin
      if (cr[CR_BCAST] || cmh_q[CMH_MSG])
      begin
        nxt_byte[eng_s] <= cml_q;
      end
      else
      begin
        nxt_byte[eng_s] <= dm_rdata;
      end
      nxt_oe[eng_s]  <= cr[CR_BCAST] | cmh_q[CMH_OE];
      nxt_cst[eng_s] <= cmh_rdata[CMH_CST];
    end
  end

  a_msg_byte: assert property ((eng == E_STORE) && (cr[CR_BCAST] || cmh_q[CMH_MSG])
    |=> nxt_byte[$past(eng_s)] === $past(cml_q));
  a_switch_byte: assert property ((eng == E_STORE) && !cr[CR_BCAST] && !cmh_q[CMH_MSG]
    |=> nxt_byte[$past(eng_s)] === $past(dm_rdata));
  a_drive_select: assert property ((eng == E_STORE)
    |=> nxt_oe[$past(eng_s)] === ($past(cr[CR_BCAST]) | $past(cmh_q[CMH_OE])));
  a_cst_early: assert property ((eng == E_STORE)
    |=> nxt_cst[$past(eng_s)] === $past(cmh_rdata[CMH_CST]));

  // memory port steering
  assign h_addr = {cr[CR_STREAM_LO +: 3], hq.idx};
  always_comb
  begin
    dm_we    = (eng == E_WRITE);
    dm_waddr = {eng_s, head.chan};
    dm_wdata = head.bytes[eng_s];
    dm_raddr = (eng == E_HOST) ? h_addr : cml_rdata;
    cm_raddr = {eng_s, eng_ch1};
    cml_we   = 1'b0;
    cmh_we   = 1'b0;
    if (eng == E_ROUTE)
    begin
      cm_raddr = {eng_s, eng_ch2};
    end
    else if (eng == E_HOST)
    begin
      cm_raddr = h_addr;
      if (hq.region && !hq.rw)
      begin
        cml_we = cr[CR_SPLIT] || (cr[CR_MSEL_LO +: 2] == MSEL_CML);
        cmh_we = !cr[CR_SPLIT] && (cr[CR_MSEL_LO +: 2] == MSEL_CMH);
      end
    end
  end

  // memories: data, low connection, high connection
  tcs_ram u_dm (.clk_sys(clk_sys), .we(dm_we), .waddr(dm_waddr), .wdata(dm_wdata),
                .raddr(dm_raddr), .rdata(dm_rdata));
  tcs_ram u_cml (.clk_sys(clk_sys), .we(cml_we), .waddr(h_addr), .wdata(hq.data),
                 .raddr(cm_raddr), .rdata(cml_rdata));
  tcs_ram u_cmh (.clk_sys(clk_sys), .we(cmh_we), .waddr(h_addr), .wdata(hq.data),
                 .raddr(cm_raddr), .rdata(cmh_rdata));

  // host read data; data memory writes from the host are dropped
  always_comb
  begin
    if (!hq.region)
    begin
      h_rd = cr;
    end
    else if (cr[CR_SPLIT] || !cr[CR_MSEL_LO + 1])
    begin
      h_rd = dm_rdata;
    end
    else if (cr[CR_MSEL_LO +: 2] == MSEL_CML)
    begin
      h_rd = cml_rdata;
    end
    else
    begin
      h_rd = cmh_rdata & CMH_MASK;
    end
  end

  assign sel = ~hp.cs_n & hp.ds;

  // host port: control writes fast, all else waits for the engine
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      h_state           <= H_IDLE;
      hq                <= '{cs_n: 1'b1, default: '0};
      cr                <= CR_RESET;
      transfer_ack_n    <= 1'b1;
      transfer_ack_oe   <= 1'b0;
      host_data_bus_out <= 8'h00;
      host_data_bus_oe  <= 1'b0;
    end
    else
    begin
      unique case (h_state)
        H_IDLE:
        begin
          if (sel)
          begin
            hq <= hp;
            if (!hp.region && !hp.rw)
            begin
              cr              <= hp.data;
              h_state         <= H_ACK;
              transfer_ack_n  <= 1'b0;
              transfer_ack_oe <= 1'b1;
            end
            else
            begin
              h_state <= H_WAIT;
            end
          end
        end
        H_WAIT:
        begin
          if (eng == E_HREAD)
          begin
            h_state           <= H_ACK;
            transfer_ack_n    <= 1'b0;
            transfer_ack_oe   <= 1'b1;
            host_data_bus_out <= h_rd;
            host_data_bus_oe  <= hq.rw;
          end
        end
        H_ACK:
        begin
          if (!sel)
          begin
            h_state          <= H_IDLE;
            transfer_ack_n   <= 1'b1;
            transfer_ack_oe  <= 1'b0;
            host_data_bus_oe <= 1'b0;
          end
        end
        default: h_state <= H_IDLE;
      endcase
    end
  end

  sequence s_slow_req;
    (h_state == H_IDLE) && sel && (hp.region || hp.rw);
  endsequence
  sequence s_ack_seen;
    !transfer_ack_n && transfer_ack_oe;
  endsequence
  a_ctrl_fast: assert property ((h_state == H_IDLE) && sel && !hp.region && !hp.rw
    |=> (cr == $past(hp.data)) && !transfer_ack_n);
  a_ack_bound: assert property (s_slow_req |=> transfer_ack_n ##[1:80] s_ack_seen);
  a_ack_release: assert property (!transfer_ack_n && !sel
    |=> transfer_ack_n && !transfer_ack_oe);
endmodule : tcs_switch

// *** tcs_tdm_peer.sv ***
`timescale 1ns/1ps
// codec side of the serial link: makes link timing, sends and captures streams
module tcs_tdm_peer
  import tcs_pkg::*;
(
  // link timing
  output logic            bit_clock_4m_n,
  output logic            frame_pulse_n,
  // streams
  output logic      [7:0] serial_in_stream,
  input  wire logic [7:0] serial_out_stream,
  input  wire logic [7:0] serial_out_oe,
  input  wire logic       control_bit_serial_out
);
  logic [8:0] pcnt;           // count the device should hold
  logic [7:0] b;              // byte being sent
  int         frames;         // frame starts seen
  logic [7:0] rx_data [256];  // captured byte per {stream, channel}
  logic       rx_oe   [256];  // driver state per {stream, channel}
  logic       cst     [256];  // control bits per {channel, cell}
  // free running clock, phase unrelated to the system clock
  initial
  begin
    bit_clock_4m_n   = 1'b1;
    frame_pulse_n    = 1'b0;
    serial_in_stream = 8'hff;
    pcnt             = 9'h1ff;
    frames           = 0;
    #37;
    forever #80 bit_clock_4m_n = ~bit_clock_4m_n;
  end
  // fixed pattern, distinct per stream and channel
  function automatic logic [7:0] in_byte(input logic [2:0] s, input logic [4:0] c);
    return {c, s} ^ 8'ha5;
  endfunction : in_byte
  // cell start: advance count, launch next bit msb first
  always @(negedge bit_clock_4m_n)
  begin
    pcnt = pcnt + 9'h001;
    if (pcnt == 9'h000)
      frames = frames + 1;
    if (!pcnt[0])
      for (int s = 0; s < 8; s++)
      begin
        b = in_byte(s[2:0], pcnt[8:4]);
        serial_in_stream[s] = b[3'h7 - pcnt[3:1]];
      end
  end
  // frame pulse spans the edge that starts count 0; outputs read late in the cell
  always @(posedge bit_clock_4m_n)
  begin
    frame_pulse_n <= (pcnt != 9'h1ff);
    if (pcnt[0])
    begin
      // late in the cell so the device's sync delay has settled
      for (int s = 0; s < 8; s++)
      begin
        rx_data[{s[2:0], pcnt[8:4]}][3'h7 - pcnt[3:1]] <= serial_out_stream[s];
        rx_oe[{s[2:0], pcnt[8:4]}]                      <= serial_out_oe[s];
      end
      cst[{pcnt[8:4], pcnt[3:1]}] <= control_bit_serial_out;
    end
  end
endmodule : tcs_tdm_peer

// *** tcs_switch_tb.sv ***
`timescale 1ns/1ps
// host-side bench for the channel switch
module tcs_switch_tb;
  import tcs_pkg::*;
  logic       clk_sys, rst, output_driver_gate;
  logic       chip_select_n, data_strobe, read_write, region_select_line;
  logic [4:0] channel_index_lines;
  logic [7:0] bus_drive;           // host side of the data bus
  logic [7:0] host_data_bus_in, host_data_bus_out;
  logic       host_data_bus_oe, transfer_ack_n, transfer_ack_oe, ack_w;
  logic       bit_clock_4m_n, frame_pulse_n, control_bit_serial_out;
  logic [7:0] serial_in_stream, serial_out_stream, serial_out_oe;
  int         n_errors, cmp_count;
  // resolved pins: device wins the data bus, pull-up on the ack line
  assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : bus_drive;
  assign ack_w            = transfer_ack_oe ? transfer_ack_n : 1'b1;
  always #10 clk_sys = ~clk_sys;
  tcs_switch DUT (.clk_sys(clk_sys), .rst(rst), .bit_clock_4m_n(bit_clock_4m_n),
    .frame_pulse_n(frame_pulse_n), .serial_in_stream(serial_in_stream),
    .output_driver_gate(output_driver_gate), .serial_out_stream(serial_out_stream),
    .serial_out_oe(serial_out_oe), .control_bit_serial_out(control_bit_serial_out),
    .chip_select_n(chip_select_n), .data_strobe(data_strobe), .read_write(read_write),
    .region_select_line(region_select_line), .channel_index_lines(channel_index_lines),
    .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
    .host_data_bus_oe(host_data_bus_oe), .transfer_ack_n(transfer_ack_n),
    .transfer_ack_oe(transfer_ack_oe));
  tcs_tdm_peer peer (.bit_clock_4m_n(bit_clock_4m_n), .frame_pulse_n(frame_pulse_n),
    .serial_in_stream(serial_in_stream), .serial_out_stream(serial_out_stream),
    .serial_out_oe(serial_out_oe), .control_bit_serial_out(control_bit_serial_out));
  // verdict and end of run
  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // byte compare
  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk8
  // single bit compare
  task automatic chk1(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk1
  // one access: hold pins until ack, take data there, then release
  task automatic host_io(input logic rd, input logic [5:0] a, input logic [7:0] wd,
                         output logic [7:0] rdv, output int lat);
    int rel;
    lat = 0;
    rel = 0;
    chip_select_n       <= 1'b0;
    data_strobe         <= 1'b1;
    read_write          <= rd;
    region_select_line  <= a[5];
    channel_index_lines <= a[4:0];
    bus_drive           <= rd ? ~bus_drive : wd;
    do
    begin
      @(posedge clk_sys);
      lat++;
    end while (ack_w !== 1'b0 && lat < 200);
    chk1("ack_seen", 1'b0, ack_w);
    chk1("data_oe", rd, host_data_bus_oe);
    rdv = host_data_bus_out;
    chip_select_n <= 1'b1;
    data_strobe   <= 1'b0;
    // next access only once the acknowledge is gone; not part of the latency
    while (ack_w !== 1'b1 && rel < 200)
    begin
      @(posedge clk_sys);
      rel++;
    end
    chk1("ack_release", 1'b1, ack_w);
  endtask : host_io
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    int         l;
    host_io(1'b0, a, d, x, l);
  endtask : wr
  // read with slow-ack check
  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] x;
    int         l;
    host_io(1'b1, a, 8'h00, x, l);
    chk8(nm, exp, x);
    chk1("rd_slow", 1'b1, l >= 6);
  endtask : rd_chk
  // page select then memory write
  task automatic wr_mem(input logic [7:0] cr, input logic [4:0] c, input logic [7:0] d);
    logic [7:0] x;
    int         l;
    wr(CR_OFFSET, cr);
    host_io(1'b0, {1'b1, c}, d, x, l);
    chk1("wr_slow", 1'b1, l >= 6);
  endtask : wr_mem
  task automatic rd_mem(input string nm, input logic [7:0] cr, input logic [4:0] c,
                        input logic [7:0] exp);
    wr(CR_OFFSET, cr);
    rd_chk(nm, {1'b1, c}, exp);
  endtask : rd_mem
  // wait for whole frames seen by the codec side
  task automatic wait_frames(input int n);
    int f0;
    f0 = peer.frames;
    while (peer.frames < f0 + n)
      @(posedge clk_sys);
  endtask : wait_frames
  // hang guard, well beyond the expected six frames
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    summarize();
  end
  // main sequence
  initial
  begin
    logic [7:0] x;
    int         l;
    clk_sys = 1'b0; rst = 1'b1; output_driver_gate = 1'b1; chip_select_n = 1'b1;
    data_strobe = 1'b0; read_write = 1'b1; region_select_line = 1'b0;
    channel_index_lines = 5'h00; bus_drive = 8'h00; n_errors = 0; cmp_count = 0;
    repeat (6) @(posedge clk_sys);
    chk8("oe_in_reset", 8'h00, serial_out_oe);
    chk1("ack_oe_reset", 1'b0, transfer_ack_oe);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd_chk("cr_reset", CR_OFFSET, CR_RESET);
    host_io(1'b0, 6'h1f, 8'h5b, x, l);
    chk1("cr_fast", 1'b1, l <= 5);
    rd_chk("cr_alias", 6'h0a, 8'h5b);
    // switched, message, message-with-driver-off, control bits
    wr_mem(8'h10, 5'd12, 8'ha7);
    wr_mem(8'h18, 5'd12, 8'h01);
    wr_mem(8'h11, 5'd20, 8'hc3);
    wr_mem(8'h19, 5'd20, 8'h05);
    wr_mem(8'h12, 5'd3, 8'h3c);
    wr_mem(8'h1a, 5'd3, 8'h04);
    wr_mem(8'h1b, 5'd9, 8'h02);
    wr_mem(8'h1c, 5'd9, 8'h00);
    wait_frames(2);
    // index is {stream, channel}; stream 5 channel 7 pattern is 98
    chk8("switched", 8'h98, peer.rx_data[8'h0c]);
    chk1("switched_oe", 1'b1, peer.rx_oe[8'h0c]);
    chk8("message", 8'hc3, peer.rx_data[8'h34]);
    chk1("driver_off", 1'b0, peer.rx_oe[8'h43]);
    // index is {channel, cell}: channel 8 cells 3 and 4
    chk1("cst_s3", 1'b1, peer.cst[8'h43]);
    chk1("cst_s4", 1'b0, peer.cst[8'h44]);
    rd_mem("cml_rd", 8'h11, 5'd20, 8'hc3);
    rd_mem("cmh_rd", 8'h19, 5'd20, 8'h05);
    rd_mem("dm_rd", 8'h05, 5'd7, 8'h98);
    // split: write lands in low entry, read comes from data memory
    wr(CR_OFFSET, 8'h96);
    wr(6'h24, 8'h5e);
    rd_chk("split_rd", 6'h24, 8'h83);
    rd_mem("split_wr", 8'h16, 5'd4, 8'h5e);
    // broadcast: low entries go out raw, all drivers on
    wr(CR_OFFSET, 8'h40);
    wait_frames(2);
    chk1("bc_oe", 1'b1, peer.rx_oe[8'h43]);
    chk8("bc_msg", 8'h3c, peer.rx_data[8'h43]);
    chk8("bc_raw", 8'ha7, peer.rx_data[8'h0c]);
    chk8("msg_repeat", 8'hc3, peer.rx_data[8'h34]);
    // gate low floats everything despite broadcast
    output_driver_gate <= 1'b0;
    wait_frames(2);
    chk8("gate_oe", 8'h00, serial_out_oe);
    chk1("gate_frame", 1'b0, peer.rx_oe[8'h34]);
    summarize();
  end
endmodule : tcs_switch_tb
